// ### design/spl_pcs.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Both streams carry 64-bit data, valid and last; only tx has ready.
// [R2] The tx stream source marks the final word of a packet with last.
// [R3] Every block gets a 2-bit header, 10 for idle and 01 for data.
// [R4] Only the 64 payload bits are scrambled; the header is in clear.
// [R5] The tx gearbox repacks 66-bit blocks into 32-bit words losslessly.
// [R6] The rx gearbox rebuilds 66-bit blocks from 32-bit lane words.
// [R7] Lock needs a valid header in the top two bits of 64 blocks in a row.
// [R8] A bad header requests a slip, moving the boundary by one bit.
// [R9] The rx gearbox keeps a 256-bit shift register for slipping.
// [R10] Aligned blocks are descrambled, decoded and put on the rx stream.
// [R11] Scrambling is self-synchronous x^58+x^39+1, payload only.
// [R12] Rx valid is raised only while locked and never while slipping.
module spl_pcs
    import spl_pkg::*;
#(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [63:0] tx_user_stream_tdata,
    input wire logic tx_user_stream_tvalid,
    input wire logic tx_user_stream_tlast,
    output logic tx_user_stream_tready,
    output logic [31:0] pma_tx_data,
    input wire logic [31:0] pma_rx_data,
    output logic [63:0] rx_user_stream_tdata,
    output logic rx_user_stream_tvalid,
    output logic rx_user_stream_tlast,
    output logic rx_locked,
    output logic rx_slipping
);

    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int FW = PAYLOAD_W + 1;
    localparam logic [PW:0] FIFO_FULL = (PW + 1)'(FIFO_DEPTH);

    // ------------------------------------------------------------
    // scrambler and descrambler, one bit per step
    // ------------------------------------------------------------
    function automatic logic [121:0] scramble(input logic [63:0] d,
                                              input logic [57:0] s);
        logic [57:0] st;
        logic [63:0] q;
        logic b;
        st = s;
        q = '0;
        for (int i = 0; i < PAYLOAD_W; i++) begin
            b = d[i] ^ st[SCR_TAP_A] ^ st[SCR_TAP_B]; // see [R11]
            q[i] = b;
            st = {st[56:0], b};
        end
        return {st, q};
    endfunction

    function automatic logic [121:0] descramble(input logic [63:0] d,
                                                input logic [57:0] s);
        logic [57:0] st;
        logic [63:0] q;
        st = s;
        q = '0;
        for (int i = 0; i < PAYLOAD_W; i++) begin
            q[i] = d[i] ^ st[SCR_TAP_A] ^ st[SCR_TAP_B]; // see [R11]
            st = {st[56:0], d[i]};
        end
        return {st, q};
    endfunction

    // ------------------------------------------------------------
    // tx two-entry buffer
    // ------------------------------------------------------------
    logic [FW-1:0] fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] fifo_wr, fifo_rd, next_fifo_wr, next_fifo_rd;
    logic [PW:0] fifo_cnt, next_fifo_cnt;
    logic fifo_push, fifo_pop, fifo_valid;
    logic [FW-1:0] fifo_head;

    // back-pressure: the user waits whenever both entries are taken
    assign tx_user_stream_tready = (fifo_cnt != FIFO_FULL); // see [R1]
    assign fifo_push = tx_user_stream_tvalid && tx_user_stream_tready;
    assign fifo_valid = (fifo_cnt != '0);
    assign fifo_head = fifo_mem[fifo_rd];

    always_comb begin
        next_fifo_wr = fifo_wr;
        next_fifo_rd = fifo_rd;
        next_fifo_cnt = fifo_cnt;
        if (fifo_push) begin
            next_fifo_wr = (fifo_wr == PW'(FIFO_DEPTH - 1)) ? '0
                           : fifo_wr + 1'b1;
        end
        if (fifo_pop) begin
            next_fifo_rd = (fifo_rd == PW'(FIFO_DEPTH - 1)) ? '0
                           : fifo_rd + 1'b1;
        end
        if (fifo_push && !fifo_pop) begin
            next_fifo_cnt = fifo_cnt + 1'b1;
        end else if (!fifo_push && fifo_pop) begin
            next_fifo_cnt = fifo_cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifo_wr <= '0;
            fifo_rd <= '0;
            fifo_cnt <= '0;
        end else begin
            fifo_wr <= next_fifo_wr;
            fifo_rd <= next_fifo_rd;
            fifo_cnt <= next_fifo_cnt;
        end
    end

    // storage needs no reset; entries are only read once written
    always_ff @(posedge clk) begin
        if (fifo_push) begin
            fifo_mem[fifo_wr] <= {tx_user_stream_tlast, tx_user_stream_tdata};
        end
    end

    // ------------------------------------------------------------
    // tx encoder, scrambler and 66-to-32 gearbox
    // ------------------------------------------------------------
    logic [TX_SR_W-1:0] tx_sr, next_tx_sr, tx_merged;
    logic [6:0] tx_cnt, next_tx_cnt;
    logic [57:0] tx_scr, next_tx_scr;
    logic tx_end_pend, next_tx_end_pend, tx_take;
    logic [31:0] next_pma_tx_data;
    logic [1:0] tx_hdr;
    logic [63:0] tx_plain;
    logic [121:0] tx_scr_out;

    // a new block is pulled only when fewer than one lane word remains
    assign tx_take = (tx_cnt < TX_LOW_MARK);
    assign fifo_pop = tx_take && !tx_end_pend && fifo_valid;

    always_comb begin
        next_tx_end_pend = tx_end_pend;
        if (tx_take && tx_end_pend) begin
            // packet end travels as its own control block
            tx_hdr = SYNC_IDLE; // see [R3]
            tx_plain = {56'h0, CTRL_END};
            next_tx_end_pend = 1'b0;
        end else if (tx_take && fifo_valid) begin
            tx_hdr = SYNC_DATA; // see [R3]
            tx_plain = fifo_head[63:0];
            next_tx_end_pend = fifo_head[64]; // see [R2]
        end else begin
            tx_hdr = SYNC_IDLE; // see [R3]
            tx_plain = {56'h0, CTRL_IDLE};
        end
        tx_scr_out = scramble(tx_plain, tx_scr); // see [R4]
        next_tx_scr = tx_take ? tx_scr_out[121:64] : tx_scr;
        tx_merged = tx_sr;
        if (tx_take) begin
            // header stays in clear in the block's first two line bits
            tx_merged = tx_sr | ({32'h0, tx_scr_out[63:0], tx_hdr}
                                 << tx_cnt); // see [R4] [R5]
        end
        next_pma_tx_data = tx_merged[31:0]; // see [R5]
        next_tx_sr = tx_merged >> LANE_W;
        next_tx_cnt = tx_take ? tx_cnt + TX_ADD_BLOCK : tx_cnt - TX_DRAIN;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_sr <= '0;
            tx_cnt <= '0;
            tx_scr <= SCR_RESET;
            tx_end_pend <= 1'b0;
            pma_tx_data <= '0;
        end else begin
            tx_sr <= next_tx_sr;
            tx_cnt <= next_tx_cnt;
            tx_scr <= next_tx_scr;
            tx_end_pend <= next_tx_end_pend;
            pma_tx_data <= next_pma_tx_data;
        end
    end

    // ------------------------------------------------------------
    // rx 32-to-66 gearbox with one-bit slip
    // ------------------------------------------------------------
    logic [RX_SR_W-1:0] rx_sr, next_rx_sr, rx_app;
    logic [8:0] rx_cnt, next_rx_cnt, rx_cnt_app, rx_need;
    logic rx_take;
    logic [65:0] rx_raw, rx_block;
    spl_aln_e aln, next_aln;
    logic slip_req;

    assign slip_req = (aln == ALN_SLIP); // see [R8]

    always_comb begin
        rx_app = rx_sr | ({224'h0, pma_rx_data} << rx_cnt); // see [R6] [R9]
        rx_cnt_app = rx_cnt + RX_WORD_BITS;
        rx_need = slip_req ? RX_SLIP_BITS : RX_BLOCK_BITS;
        rx_take = (rx_cnt_app >= rx_need);
        // on a slip one extra line bit is discarded ahead of the block
        rx_raw = slip_req ? rx_app[66:1] : rx_app[65:0]; // see [R8]
        // rebuilt block carries its sync header in the two top bits
        rx_block = {rx_raw[1:0], rx_raw[65:2]}; // see [R6]
        next_rx_sr = rx_app;
        next_rx_cnt = rx_cnt_app;
        if (rx_take) begin
            next_rx_sr = rx_app >> rx_need; // see [R8]
            next_rx_cnt = rx_cnt_app - rx_need;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_sr <= '0;
            rx_cnt <= '0;
        end else begin
            rx_sr <= next_rx_sr;
            rx_cnt <= next_rx_cnt;
        end
    end

    // ------------------------------------------------------------
    // aligner
    // ------------------------------------------------------------
    logic [6:0] good_cnt, next_good_cnt;
    logic hdr_ok;

    assign hdr_ok = (rx_block[65:64] == SYNC_DATA)
                    || (rx_block[65:64] == SYNC_IDLE); // see [R7]

    always_comb begin
        next_aln = aln;
        next_good_cnt = good_cnt;
        if (rx_take) begin
            case (aln)
                ALN_HUNT: begin
                    if (!hdr_ok) begin
                        next_aln = ALN_SLIP; // see [R8]
                        next_good_cnt = '0;
                    end else if (good_cnt == LOCK_BLOCKS - 7'h1) begin
                        next_aln = ALN_LOCK; // see [R7]
                        next_good_cnt = '0;
                    end else begin
                        next_good_cnt = good_cnt + 7'h1;
                    end
                end
                ALN_SLIP: begin
                    // the block cut during the slip is never judged
                    next_aln = ALN_HUNT;
                    next_good_cnt = '0;
                end
                ALN_LOCK: begin
                    if (!hdr_ok) begin
                        next_aln = ALN_SLIP; // see [R8]
                    end
                end
                default: begin
                    next_aln = ALN_HUNT;
                    next_good_cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aln <= ALN_HUNT;
            good_cnt <= '0;
        end else begin
            aln <= next_aln;
            good_cnt <= next_good_cnt;
        end
    end

    assign rx_locked = (aln == ALN_LOCK);
    assign rx_slipping = slip_req;

    // ------------------------------------------------------------
    // rx descrambler and decoder
    // ------------------------------------------------------------
    logic [57:0] rx_scr, next_rx_scr;
    logic [121:0] rx_dsc;
    logic [63:0] hold, next_hold, next_rx_tdata;
    logic hold_v, next_hold_v, next_rx_tvalid, next_rx_tlast;

    // a data word is held back until the next data or end block so that the end marker that
    // follows it can raise last; a lock loss drops the held word
    always_comb begin
        rx_dsc = descramble(rx_block[63:0], rx_scr); // see [R10]
        next_rx_scr = rx_take ? rx_dsc[121:64] : rx_scr;
        next_hold = hold;
        next_hold_v = hold_v;
        next_rx_tdata = rx_user_stream_tdata;
        next_rx_tvalid = 1'b0;
        next_rx_tlast = rx_user_stream_tlast;
        if (aln != ALN_LOCK) begin
            next_hold_v = 1'b0; // see [R12]
        end else if (rx_take && hdr_ok) begin
            if (rx_block[65:64] == SYNC_DATA) begin
                if (hold_v) begin
                    next_rx_tdata = hold; // see [R10]
                    next_rx_tvalid = 1'b1; // see [R12]
                    next_rx_tlast = 1'b0;
                end
                next_hold = rx_dsc[63:0];
                next_hold_v = 1'b1;
            end else if (rx_dsc[7:0] == CTRL_END && hold_v) begin
                next_rx_tdata = hold; // see [R10]
                next_rx_tvalid = 1'b1; // see [R12]
                next_rx_tlast = 1'b1; // see [R1]
                next_hold_v = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_scr <= SCR_RESET;
            hold <= '0;
            hold_v <= 1'b0;
            rx_user_stream_tdata <= '0;
            rx_user_stream_tvalid <= 1'b0;
            rx_user_stream_tlast <= 1'b0;
        end else begin
            rx_scr <= next_rx_scr;
            hold <= next_hold;
            hold_v <= next_hold_v;
            rx_user_stream_tdata <= next_rx_tdata;
            rx_user_stream_tvalid <= next_rx_tvalid;
            rx_user_stream_tlast <= next_rx_tlast;
        end
    end

endmodule

// ### inc/spl_pkg.sv
package spl_pkg;

    // ------------------------------------------------------------
    // line block format
    // ------------------------------------------------------------
    localparam int PAYLOAD_W = 64;
    localparam int HDR_W = 2;
    localparam int BLOCK_W = 66;
    localparam int LANE_W = 32;
    localparam logic [1:0] SYNC_DATA = 2'h1;
    localparam logic [1:0] SYNC_IDLE = 2'h2;

    // control block type byte, carried in payload bits [7:0]
    localparam logic [7:0] CTRL_IDLE = 8'h1e;
    localparam logic [7:0] CTRL_END = 8'h87;

    // ------------------------------------------------------------
    // scrambler x^58 + x^39 + 1
    // ------------------------------------------------------------
    localparam int SCR_W = 58;
    localparam int SCR_TAP_A = 38;
    localparam int SCR_TAP_B = 57;
    localparam logic [57:0] SCR_RESET = 58'h3ff_ffff_ffff_ffff;

    // ------------------------------------------------------------
    // gearboxes and aligner
    // ------------------------------------------------------------
    localparam int TX_SR_W = 98;
    localparam logic [6:0] TX_LOW_MARK = 7'h20;
    localparam logic [6:0] TX_ADD_BLOCK = 7'h22;
    localparam logic [6:0] TX_DRAIN = 7'h20;
    localparam int RX_SR_W = 256;
    localparam logic [8:0] RX_WORD_BITS = 9'h020;
    localparam logic [8:0] RX_BLOCK_BITS = 9'h042;
    localparam logic [8:0] RX_SLIP_BITS = 9'h043;
    localparam logic [6:0] LOCK_BLOCKS = 7'h40;

    typedef enum logic [2:0] {
        ALN_HUNT = 3'h1,
        ALN_SLIP = 3'h2,
        ALN_LOCK = 3'h4
    } spl_aln_e;

endpackage

// ### tb/spl_pcs_bench.sv
`timescale 1ns/1ps
module spl_pcs_bench;
    typedef struct packed {
        logic [63:0] data;
        logic last;
    } spl_row_s;
    // loopback: each row's word and last come back unchanged
    localparam spl_row_s ROWS [8] = '{
        '{64'h0, 1'h0}, '{64'hffff_ffff_ffff_ffff, 1'h0},
        '{64'h0123_4567_89ab_cd87, 1'h1}, '{64'h1e, 1'h1},
        '{64'h8000_0000_0000_0001, 1'h1}, '{64'h5555_aaaa_5555_aaaa, 1'h0},
        '{64'hdead_beef_0bad_f00d, 1'h0}, '{64'h0f0f_f0f0_3c3c_c3c3, 1'h1}};
    logic clk, rst_n, tx_valid, tx_last, tx_ready, zap;
    logic rx_valid, rx_last, locked, slipping, saw_stall, saw_slip;
    logic [63:0] tx_data, rx_data;
    logic [31:0] tx_lane, rx_lane;
    logic [4:0] shift;
    int error_cnt, comparisons;
    spl_row_s exp_q[$];
    spl_row_s mon_exp;

    spl_pcs #(.FIFO_DEPTH(2)) spl_pcs_i (
        .clk(clk), .rst_n(rst_n), .tx_user_stream_tdata(tx_data),
        .tx_user_stream_tvalid(tx_valid), .tx_user_stream_tlast(tx_last),
        .tx_user_stream_tready(tx_ready), .pma_tx_data(tx_lane),
        .pma_rx_data(rx_lane), .rx_user_stream_tdata(rx_data),
        .rx_user_stream_tvalid(rx_valid), .rx_user_stream_tlast(rx_last),
        .rx_locked(locked), .rx_slipping(slipping));
    spl_pma_model spl_pma_model_i (.clk(clk), .tx_word(tx_lane),
        .shift(shift), .zap(zap), .rx_word(rx_lane));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // compare and drive tasks
    // ----------------------------------------
    task automatic check64(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: word %h not %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp, input string m);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic summarize;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // holds the word until ready is seen at a sampling edge
    task automatic send(input spl_row_s r);
        logic rdy;
        #1;
        tx_valid = 1'b1;
        tx_data = r.data;
        tx_last = r.last;
        exp_q.push_back(r);
        rdy = 1'b0;
        while (!rdy) begin
            @(negedge clk);
            rdy = (tx_ready === 1'b1);
            @(posedge clk);
        end
    endtask
    task automatic idle(input int n);
        #1 tx_valid = 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_lock;
        int n;
        n = 0;
        while (locked !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        check1(locked, 1'b1, "no lock");
        @(posedge clk);
    endtask

    always @(negedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b0) saw_stall = 1'b1;
        if (slipping === 1'b1) saw_slip = 1'b1;
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check1(1'b0, 1'b1, "stray rx word");
            end else begin
                mon_exp = exp_q.pop_front();
                check64(rx_data, mon_exp.data);
                check1(rx_last, mon_exp.last, "last marker");
            end
        end
    end

    initial begin
        #2000000;
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        summarize();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        tx_valid = 1'b0;
        tx_last = 1'b0;
        tx_data = 64'h0;
        shift = 5'hd;
        zap = 1'b0;
        saw_stall = 1'b0;
        saw_slip = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        wait_lock();
        foreach (ROWS[i]) send(ROWS[i]);
        idle(200);
        check1(exp_q.size() == 0, 1'b1, "words lost");
        check1(saw_stall, 1'b1, "buffer never full");
        // zeroed words followed by a new offset must break lock
        #1 zap = 1'b1;
        repeat (3) @(posedge clk);
        #1 zap = 1'b0;
        shift = 5'h5;
        saw_slip = 1'b0;
        repeat (8) @(negedge clk);
        check1(locked, 1'b0, "lock kept after bad headers");
        @(posedge clk);
        wait_lock();
        check1(saw_slip, 1'b1, "no slip seen");
        send(ROWS[1]);
        send(ROWS[2]);
        idle(100);
        check1(exp_q.size() == 0, 1'b1, "lost after relock");
        #1 rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check1(tx_ready, 1'b1, "ready in reset");
        check64({32'h0, tx_lane}, 64'h0);
        check1(locked, 1'b0, "locked in reset");
        check1(rx_valid, 1'b0, "rx valid in reset");
        @(posedge clk);
        #1 rst_n = 1'b1;
        summarize();
    end
endmodule

// ### tb/spl_pcs_chk.sv
`timescale 1ns/1ps
module spl_pcs_chk
    import spl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [63:0] tx_user_stream_tdata,
    input wire logic tx_user_stream_tvalid,
    input wire logic tx_user_stream_tlast,
    input wire logic tx_user_stream_tready,
    input wire logic [31:0] pma_tx_data,
    input wire logic [31:0] pma_rx_data,
    input wire logic [63:0] rx_user_stream_tdata,
    input wire logic rx_user_stream_tvalid,
    input wire logic rx_user_stream_tlast,
    input wire logic rx_locked,
    input wire logic rx_slipping
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    // 64 blocks of 66 bits need at least 132 lane words of hunting
    logic [7:0] hunt_cnt;
    logic [2:0] same_cnt;
    logic [31:0] last_lane;
    always_ff @(posedge clk) begin
        if (!rst_n || rx_slipping || rx_locked) begin
            hunt_cnt <= 8'h00;
        end else if (hunt_cnt != 8'hff) begin
            hunt_cnt <= hunt_cnt + 8'h01;
        end
        last_lane <= pma_tx_data;
        if (!rst_n || pma_tx_data != last_lane) begin
            same_cnt <= 3'h0;
        end else if (same_cnt != 3'h7) begin
            same_cnt <= same_cnt + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    rx_valid_locked_a: assert property (
        rx_user_stream_tvalid |-> rx_locked)
        else $error("rx word outside lock");
    lock_slip_excl_a: assert property (
        !(rx_locked && rx_slipping))
        else $error("locked while slipping");
    rx_pulse_one_a: assert property (
        rx_user_stream_tvalid |=> !rx_user_stream_tvalid)
        else $error("rx words closer than one block");
    lock_count_a: assert property (
        $rose(rx_locked) |-> hunt_cnt >= 8'h80)
        else $error("lock after too few blocks");
    slip_short_a: assert property (
        $rose(rx_slipping) |-> ##[1:6] !rx_slipping)
        else $error("slip never finished");
    lock_loss_slip_a: assert property (
        $fell(rx_locked) |-> rx_slipping)
        else $error("lock lost without slip");
    tready_back_a: assert property (
        !tx_user_stream_tready |-> ##[1:10] tx_user_stream_tready)
        else $error("tx stream stalled for good");
    tx_scrambled_a: assert property (
        same_cnt < 3'h6)
        else $error("lane word frozen");

    cover property ($rose(rx_locked));
    cover property ($rose(rx_slipping));
    cover property (rx_user_stream_tvalid && rx_user_stream_tlast);
    cover property (tx_user_stream_tvalid && !tx_user_stream_tready);
endmodule

bind spl_pcs spl_pcs_chk spl_pcs_chk_i (
    .clk(clk), .rst_n(rst_n),
    .tx_user_stream_tdata(tx_user_stream_tdata),
    .tx_user_stream_tvalid(tx_user_stream_tvalid),
    .tx_user_stream_tlast(tx_user_stream_tlast),
    .tx_user_stream_tready(tx_user_stream_tready),
    .pma_tx_data(pma_tx_data), .pma_rx_data(pma_rx_data),
    .rx_user_stream_tdata(rx_user_stream_tdata),
    .rx_user_stream_tvalid(rx_user_stream_tvalid),
    .rx_user_stream_tlast(rx_user_stream_tlast),
    .rx_locked(rx_locked), .rx_slipping(rx_slipping)
);

// ### tb/spl_pma_model.sv
`timescale 1ns/1ps
module spl_pma_model (
    input wire logic clk,
    input wire logic [31:0] tx_word,
    input wire logic [4:0] shift,
    input wire logic zap,
    output logic [31:0] rx_word
);
    // ----------------------------------------
    // lane loopback
    // ----------------------------------------
    // shift delays the line by that many bits, so the rx side must hunt
    // for the boundary; zap zeroes a word, and no 00 header is valid
    logic [31:0] prev;
    logic [63:0] both;
    assign both = {tx_word, prev};
    always_ff @(posedge clk) begin
        prev <= tx_word;
        rx_word <= zap ? 32'h0 : both[6'h20 - shift +: 32];
    end
endmodule
